// File: common/sfts_map.vh
// Constants for the strobe frame trigger sequencer: register offsets, fields, reset values.
// Assumes APB with 32-bit data and word-aligned registers.
`ifndef SFTS_MAP_VH
`define SFTS_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SFTS_CTRL_ADDR      12'h000
`define SFTS_STATUS_ADDR    12'h004
`define SFTS_SNAP_ADDR      12'h008

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define SFTS_CTRL_RATE_LSB  0
`define SFTS_CTRL_RATE_MSB  2
`define SFTS_CTRL_MODE_LSB  4
`define SFTS_CTRL_MODE_MSB  5
`define SFTS_CTRL_SHUT_BIT  8
`define SFTS_CTRL_CHECK_BIT 9
`define SFTS_CTRL_PLAY_BIT  10
`define SFTS_CTRL_RESET     32'h0000_0000

// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define SFTS_MODE_INT       2'h0
`define SFTS_MODE_EXT       2'h1
`define SFTS_MODE_MAN       2'h2
`define SFTS_SRC_LIVE       2'h0
`define SFTS_SRC_STORED     2'h1
`define SFTS_SRC_RECORDED   2'h2
`define SFTS_SRC_CHECKER    2'h3
`define SFTS_CAMERA_FPS     30

`endif

// File: design/sfts_frame_store.v
// Single-frame buffer memory: one write port, one registered read port.
// Assumes the writer and reader walk pixel addresses in step with camera video.
`timescale 1ns/1ps

module sfts_frame_store #(
    parameter DW = 8,
    parameter AW = 10
) (
    // Clock
    input  wire          sys_clk,
    // Write side
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read side
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// File: design/sfts_sequencer.v
// Frame sequencer, trigger modes and monitor selection for a strobe camera controller.
// Assumes camera video arrives as pixel strobes with a frame-start pulse, all on sys_clk.
`timescale 1ns/1ps
`include "sfts_map.vh"

module sfts_sequencer #(
    parameter DW = 8,
    parameter AW = 10,
    parameter CW = 8
) (
    // Clock and reset
    input  wire          sys_clk,
    input  wire          rst,
    // APB slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    // Camera video
    input  wire          cam_frame_start,
    input  wire          cam_pixel_valid,
    input  wire [DW-1:0] cam_pixel,
    input  wire [DW-1:0] rec_pixel,
    // External triggers
    input  wire          shutter_trigger,
    input  wire          frame_trigger,
    // Outputs
    output reg           shutter_fire,
    output reg           strobe_fire,
    output reg  [DW-1:0] monitor_pixel,
    output reg           monitor_valid
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [2:0]    rate_sel;
    reg  [1:0]    trig_mode;
    reg           shutter_on;
    reg           checker_req;
    reg           playback_req;
    reg           snap_req;
    reg  [CW-1:0] frame_cnt;
    reg  [AW-1:0] pix_addr;
    reg  [AW-1:0] rd_addr_q;
    reg           capturing;
    reg           pend_acq;
    reg           acq_done;
    reg  [31:0]   acq_count;
    reg           valid_q;
    reg  [DW-1:0] cam_q;
    reg  [DW-1:0] rec_q;
    reg           trig_q;
    reg  [1:0]    src_q;
    wire [DW-1:0] stored_pixel;
    reg  [CW-1:0] div;
    reg  [1:0]    src;
    reg  [1:0]    next_mode;

    wire wr_xfer = psel & penable & pwrite;
    wire ctrl_hit = (paddr == `SFTS_CTRL_ADDR);
    wire snap_hit = (paddr == `SFTS_SNAP_ADDR);
    wire stat_hit = (paddr == `SFTS_STATUS_ADDR);

    // Zero wait states: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(ctrl_hit | snap_hit | stat_hit);

    // Frame interval in camera frames for each rate setting.
    always @* begin
        case (rate_sel)
            3'h0:    div = 8'd1;   // 30 fps
            3'h1:    div = 8'd2;   // 15 fps
            3'h2:    div = 8'd3;   // 10 fps
            3'h3:    div = 8'd5;   // 6 fps
            3'h4:    div = 8'd6;   // 5 fps
            3'h5:    div = 8'd10;  // 3 fps
            default: div = 8'd30;  // 1 fps
        endcase
    end

    // ------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------
    // A trigger counts on its rising edge; either connector may fire it.
    wire trig_in   = shutter_trigger | frame_trigger;
    wire trig_rise = trig_in & ~trig_q;
    // Greater-or-equal lets a rate change in mid-count fire at the next frame start
    // instead of waiting for the counter to wrap through its full range.
    wire int_fire  = cam_frame_start && (trig_mode == `SFTS_MODE_INT) &&
                     (frame_cnt >= div - 8'd1);
    wire ext_fire  = trig_rise && (trig_mode != `SFTS_MODE_INT);
    wire man_fire  = snap_req;

    // ------------------------------------------------------------
    // Control register and mode
    // ------------------------------------------------------------
    always @* begin
        next_mode = trig_mode;
        if (wr_xfer && ctrl_hit) begin
            // Only the three legal modes are accepted; anything else keeps the old one.
            if (pwdata[`SFTS_CTRL_MODE_MSB:`SFTS_CTRL_MODE_LSB] != 2'h3) begin
                next_mode = pwdata[`SFTS_CTRL_MODE_MSB:`SFTS_CTRL_MODE_LSB];
            end
        end
        if (snap_req) begin
            next_mode = `SFTS_MODE_EXT;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_sel     <= 3'h0;
            trig_mode    <= `SFTS_MODE_INT;
            shutter_on   <= 1'b0;
            checker_req  <= 1'b0;
            playback_req <= 1'b0;
            snap_req     <= 1'b0;
            trig_q       <= 1'b0;
        end else begin
            trig_q    <= trig_in;
            trig_mode <= next_mode;
            snap_req  <= 1'b0;
            if (wr_xfer && ctrl_hit) begin
                rate_sel     <= pwdata[`SFTS_CTRL_RATE_MSB:`SFTS_CTRL_RATE_LSB];
                shutter_on   <= pwdata[`SFTS_CTRL_SHUT_BIT];
                checker_req  <= pwdata[`SFTS_CTRL_CHECK_BIT];
                playback_req <= pwdata[`SFTS_CTRL_PLAY_BIT];
                if (pwdata[`SFTS_CTRL_MODE_MSB:`SFTS_CTRL_MODE_LSB] == `SFTS_MODE_MAN) begin
                    snap_req <= 1'b1;
                end
            end else if (wr_xfer && snap_hit && pwdata[0]) begin
                snap_req <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    // Camera keeps running at full rate; the counter only marks which frames are new.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_cnt    <= {CW{1'b0}};
            shutter_fire <= 1'b0;
            strobe_fire  <= 1'b0;
            pend_acq     <= 1'b0;
            capturing    <= 1'b0;
            acq_done     <= 1'b0;
            acq_count    <= 32'h0000_0000;
        end else begin
            shutter_fire <= 1'b0;
            strobe_fire  <= 1'b0;
            if (cam_frame_start) begin
                if (trig_mode != `SFTS_MODE_INT || frame_cnt >= div - 8'd1) begin
                    frame_cnt <= {CW{1'b0}};
                end else begin
                    frame_cnt <= frame_cnt + 8'd1;
                end
            end
            // Fire pulses go out at once; external and manual capture requests wait for the next frame start.
            if ((int_fire || ext_fire || man_fire) && shutter_on) begin
                shutter_fire <= 1'b1;
                strobe_fire  <= 1'b1;
            end
            if (int_fire) begin
                capturing <= 1'b1;
                pend_acq  <= 1'b0;
            end else if (cam_frame_start) begin
                capturing <= pend_acq;
                if (pend_acq) begin
                    acq_count <= acq_count + 32'h0000_0001;
                end
                pend_acq <= ext_fire | man_fire;
            end else if (ext_fire || man_fire) begin
                pend_acq <= 1'b1;
            end
            if (int_fire) begin
                acq_count <= acq_count + 32'h0000_0001;
            end
            if (cam_frame_start && capturing) begin
                acq_done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer memory
    // ------------------------------------------------------------
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pix_addr <= {AW{1'b0}};
        end else if (cam_frame_start) begin
            pix_addr <= {AW{1'b0}};
        end else if (cam_pixel_valid) begin
            pix_addr <= pix_addr + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    // Read and write share one address: the replayed pixel leaves one cycle after its
    // slot, which the one-stage delay of the live and playback pixels matches.
    sfts_frame_store #(
        .DW (DW),
        .AW (AW)
    ) i_sfts_frame_store (
        .sys_clk (sys_clk),
        .wr_en   (capturing & cam_pixel_valid),
        .wr_addr (pix_addr),
        .wr_data (cam_pixel),
        .rd_addr (pix_addr),
        .rd_data (stored_pixel)
    );

    // ------------------------------------------------------------
    // Monitor source
    // ------------------------------------------------------------
    always @* begin
        if (shutter_on && trig_mode == `SFTS_MODE_INT && div == 8'd1) begin
            src = `SFTS_SRC_LIVE;
        end else if (shutter_on) begin
            src = capturing || !acq_done ? `SFTS_SRC_LIVE : `SFTS_SRC_STORED;
        end else if (checker_req) begin
            src = `SFTS_SRC_CHECKER;
        end else if (playback_req) begin
            src = `SFTS_SRC_RECORDED;
        end else begin
            src = `SFTS_SRC_LIVE;
        end
    end

    // Checker squares are 8 pixels wide, taken from pixel address bits.
    // The delayed address is used so the pattern lines up with the pixel leaving the
    // output stage; with no line count, address bit AW-1 inverts the squares for the upper half of the buffer.
    wire checker_bit = rd_addr_q[3] ^ rd_addr_q[AW-1];

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            valid_q       <= 1'b0;
            cam_q         <= {DW{1'b0}};
            rec_q         <= {DW{1'b0}};
            src_q         <= `SFTS_SRC_LIVE;
            rd_addr_q     <= {AW{1'b0}};
            monitor_pixel <= {DW{1'b0}};
            monitor_valid <= 1'b0;
        end else begin
            // One stage delay so live and playback pixels line up with the memory read.
            valid_q       <= cam_pixel_valid;
            cam_q         <= cam_pixel;
            rec_q         <= rec_pixel;
            src_q         <= src;
            rd_addr_q     <= pix_addr;
            monitor_valid <= valid_q;
            case (src_q)
                `SFTS_SRC_LIVE:     monitor_pixel <= cam_q;
                `SFTS_SRC_STORED:   monitor_pixel <= stored_pixel;
                `SFTS_SRC_RECORDED: monitor_pixel <= rec_q;
                `SFTS_SRC_CHECKER:  monitor_pixel <= {DW{checker_bit}};
                default:            monitor_pixel <= cam_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @* begin
        prdata = 32'h0000_0000;
        if (ctrl_hit) begin
            prdata[`SFTS_CTRL_RATE_MSB:`SFTS_CTRL_RATE_LSB] = rate_sel;
            prdata[`SFTS_CTRL_MODE_MSB:`SFTS_CTRL_MODE_LSB] = trig_mode;
            prdata[`SFTS_CTRL_SHUT_BIT]  = shutter_on;
            prdata[`SFTS_CTRL_CHECK_BIT] = checker_req;
            prdata[`SFTS_CTRL_PLAY_BIT]  = playback_req;
        end else if (stat_hit) begin
            prdata = {acq_count[23:0], 2'h0, src, capturing, pend_acq, acq_done, 1'b0};
        end
    end

endmodule

// File: sim/sfts_asserts.sv
// Port checker for the sequencer.
// Assumes zero-wait APB and the two-cycle video delay.
`timescale 1ns/1ps
`include "sfts_map.vh"

module sfts_asserts (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Video, triggers and outputs
    input wire        cam_frame_start,
    input wire        cam_pixel_valid,
    input wire        shutter_trigger,
    input wire        frame_trigger,
    input wire        shutter_fire,
    input wire        strobe_fire,
    input wire        monitor_valid
);
    // ----
    // Expected control contents
    // ----
    reg  [31:0] lc;
    reg  [1:0]  me;
    wire        wa = psel && penable && pwrite;
    wire        cw = wa && paddr == `SFTS_CTRL_ADDR;
    wire        cr = psel && penable && !pwrite && paddr == `SFTS_CTRL_ADDR;
    // The manual position is momentary, so it is expected to read as external.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lc <= `SFTS_CTRL_RESET;
            me <= `SFTS_MODE_INT;
        end else if (cw) begin
            lc <= pwdata;
            if (pwdata[5:4] == `SFTS_MODE_MAN)
                me <= `SFTS_MODE_EXT;
            else if (pwdata[5:4] != 2'h3)
                me <= pwdata[5:4];
        end else if (wa && paddr == `SFTS_SNAP_ADDR && pwdata[0])
            me <= `SFTS_MODE_EXT;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_pulse; shutter_fire |=> !shutter_fire; endproperty
    a_pulse: assert property (p_pulse) else $error("fire pulse too long");
    property p_pair; shutter_fire == strobe_fire; endproperty
    a_pair: assert property (p_pair) else $error("strobe apart from shutter");
    property p_cause;
        shutter_fire |-> $past(cam_frame_start) || $past(shutter_trigger || frame_trigger)
            || $past(wa, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("fire without cause");
    property p_full;
        cam_frame_start && me == `SFTS_MODE_INT && lc[2:0] == 3'h0 && lc[8] |=> shutter_fire;
    endproperty
    a_full: assert property (p_full) else $error("no fire at full rate");
    property p_fields; cr |-> prdata[2:0] == lc[2:0] && prdata[10:8] == lc[10:8]; endproperty
    a_fields: assert property (p_fields) else $error("control readback");
    property p_mode; cr |-> prdata[5:4] == me; endproperty
    a_mode: assert property (p_mode) else $error("mode readback");
    property p_video; monitor_valid == $past(cam_pixel_valid, 2); endproperty
    a_video: assert property (p_video) else $error("video delay");
    property p_unmapped; pslverr |-> psel && penable && (pwrite || prdata == 32'h0); endproperty
    a_unmapped: assert property (p_unmapped) else $error("error response");
endmodule

bind sfts_sequencer sfts_asserts i_sfts_asserts (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
    .cam_frame_start, .cam_pixel_valid, .shutter_trigger, .frame_trigger,
    .shutter_fire, .strobe_fire, .monitor_valid
);

// File: sim/sfts_camera_model.sv
// Camera source: free-running short frames of pixels and a playback feed.
// Assumes one clock; a frame is LEN cycles, far shorter than real video.
`timescale 1ns/1ps

module sfts_camera_model #(
    parameter DW  = 8,
    parameter LEN = 40
) (
    // Clock and reset
    input  wire          sys_clk,
    input  wire          rst,
    // Video
    output reg           cam_frame_start,
    output reg           cam_pixel_valid,
    output reg  [DW-1:0] cam_pixel,
    output reg  [DW-1:0] rec_pixel
);
    reg [7:0] pos;
    reg [7:0] frm;
    // Pixels change every cycle, also between valid strobes, so no stale value is seen.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pos <= 8'h00;
            frm <= 8'h00;
            cam_frame_start <= 1'b0;
            cam_pixel_valid <= 1'b0;
            cam_pixel <= {DW{1'b0}};
            rec_pixel <= {DW{1'b1}};
        end else begin
            pos <= (pos == LEN - 1) ? 8'h00 : pos + 8'h01;
            frm <= (pos == LEN - 1) ? frm + 8'h01 : frm;
            cam_frame_start <= (pos == LEN - 1);
            cam_pixel_valid <= (pos >= 8'h01 && pos <= 8'h10);
            cam_pixel <= DW'(frm ^ pos);
            rec_pixel <= DW'(~(frm + pos));
        end
    end
endmodule

// File: sim/strobe_frame_trigger_sequencer_test.sv
// Testbench: rates, sources, external and manual triggers over APB.
// Assumes the camera model on the video side.
`timescale 1ns/1ps
`include "sfts_map.vh"

module strobe_frame_trigger_sequencer_test;
    reg          sys_clk = 1'b0;
    reg          rst = 1'b1;
    reg          psel = 1'b0;
    reg          penable = 1'b0;
    reg          pwrite = 1'b0;
    reg  [11:0]  paddr = 12'h000;
    reg  [31:0]  pwdata = 32'h0;
    reg          shutter_trigger = 1'b0;
    reg          frame_trigger = 1'b0;
    wire [31:0]  prdata;
    wire         pready, pslverr, cam_frame_start, cam_pixel_valid;
    wire         shutter_fire, strobe_fire, monitor_valid;
    wire [7:0]   cam_pixel, rec_pixel, monitor_pixel;
    integer      n_mismatch = 0;
    integer      tests_run = 0;
    integer      n_fire = 0;
    integer      f0, i;
    reg  [31:0]  rd, st;
    reg          err;
    integer      fps [0:6] = '{30, 15, 10, 6, 5, 3, 1};
    reg  [7:0]   cam_d1, cam_d2, rec_d1, rec_d2;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (shutter_fire === 1'b1) n_fire <= n_fire + 1;
    // Live and playback pixels two edges back, the latency of the monitor path.
    always @(posedge sys_clk) begin
        cam_d1 <= cam_pixel;
        cam_d2 <= cam_d1;
        rec_d1 <= rec_pixel;
        rec_d2 <= rec_d1;
    end

    sfts_camera_model i_sfts_camera_model (
        .sys_clk, .rst, .cam_frame_start, .cam_pixel_valid, .cam_pixel, .rec_pixel);
    sfts_sequencer i_sfts_sequencer (
        .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cam_frame_start, .cam_pixel_valid, .cam_pixel, .rec_pixel,
        .shutter_trigger, .frame_trigger, .shutter_fire, .strobe_fire,
        .monitor_pixel, .monitor_valid);

    // ----
    // Tasks
    // ----
    task test_done; begin
        $display("compared %0d bad %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end endtask
    task chk(input string nm, input [31:0] e, input [31:0] g); begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    end endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge sys_clk);
                k = k + 1;
            end while (pready !== 1'b1 && k < 20);
            if (k == 20) begin
                n_mismatch = n_mismatch + 1;
                test_done;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Returns at the edge that samples a frame start.
    task frames(input integer n);
        integer j, k;
        for (j = 0; j < n; j = j + 1) begin
            k = 0;
            do begin
                @(posedge sys_clk);
                k = k + 1;
            end while (cam_frame_start !== 1'b1 && k < 100);
            if (k == 100) begin
                n_mismatch = n_mismatch + 1;
                test_done;
            end
        end
    endtask
    // Checks the 16 monitor pixels of one frame against the source given by kind.
    task mon(input string nm, input [1:0] kind);
        integer j, k, n_hi;
        reg [7:0] e;
        begin
            frames(1);
            n_hi = 0;
            for (j = 0; j < 16; j = j + 1) begin
                k = 0;
                do begin
                    @(posedge sys_clk);
                    k = k + 1;
                end while (monitor_valid !== 1'b1 && k < 100);
                if (k == 100) begin
                    n_mismatch = n_mismatch + 1;
                    test_done;
                end
                e = (kind == `SFTS_SRC_RECORDED) ? rec_d2 : cam_d2;
                if (kind == `SFTS_SRC_CHECKER) begin
                    n_hi = n_hi + (monitor_pixel == 8'hff);
                    e = (monitor_pixel == 8'hff) ? 8'hff : 8'h00;
                end
                chk(nm, e, monitor_pixel);
            end
            if (kind == `SFTS_SRC_CHECKER)
                chk(nm, 8, n_hi);
        end
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, `SFTS_CTRL_ADDR, 0);
        chk("ctrl", `SFTS_CTRL_RESET, rd);
        apb(0, 12'h00c, 0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_rd", 32'h0, rd);
        $display("test reset done");
        for (i = 0; i < 7; i = i + 1) begin
            apb(1, `SFTS_CTRL_ADDR, 32'h100 | i);
            frames(2);
            f0 = n_fire;
            apb(0, `SFTS_STATUS_ADDR, 0);
            st = rd;
            frames(30);
            chk("fires", fps[i], n_fire - f0);
            apb(0, `SFTS_STATUS_ADDR, 0);
            chk("acq", fps[i], rd[31:8] - st[31:8]);
        end
        apb(1, `SFTS_CTRL_ADDR, 32'h400);
        apb(0, `SFTS_STATUS_ADDR, 0);
        f0 = n_fire;
        chk("src_rec", `SFTS_SRC_RECORDED, rd[5:4]);
        mon("mon_rec", `SFTS_SRC_RECORDED);
        chk("quiet", f0, n_fire);
        apb(1, `SFTS_CTRL_ADDR, 32'h500);
        apb(0, `SFTS_STATUS_ADDR, 0);
        chk("src_shut", `SFTS_SRC_LIVE, rd[5:4]);
        mon("mon_shut", `SFTS_SRC_LIVE);
        apb(1, `SFTS_CTRL_ADDR, 32'h200);
        apb(0, `SFTS_STATUS_ADDR, 0);
        chk("src_chk", `SFTS_SRC_CHECKER, rd[5:4]);
        mon("mon_chk", `SFTS_SRC_CHECKER);
        $display("test sources done");
        apb(1, `SFTS_CTRL_ADDR, 32'h110);
        frames(2);
        f0 = n_fire;
        apb(0, `SFTS_STATUS_ADDR, 0);
        st = rd;
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge sys_clk);
            frame_trigger <= (i == 0);
            shutter_trigger <= (i == 1);
            frames(3);
            chk("ext_fire", i + 1, n_fire - f0);
            apb(0, `SFTS_STATUS_ADDR, 0);
            chk("ext_acq", i + 1, rd[31:8] - st[31:8]);
            frame_trigger <= 1'b0;
            shutter_trigger <= 1'b0;
        end
        $display("test external done");
        f0 = n_fire;
        st = rd;
        apb(1, `SFTS_CTRL_ADDR, 32'h120);
        frames(2);
        chk("man_fire", 1, n_fire - f0);
        apb(0, `SFTS_CTRL_ADDR, 0);
        chk("man_mode", `SFTS_MODE_EXT, rd[5:4]);
        apb(1, `SFTS_SNAP_ADDR, 1);
        frames(2);
        chk("snap_fire", 2, n_fire - f0);
        apb(0, `SFTS_STATUS_ADDR, 0);
        chk("snap_acq", 2, rd[31:8] - st[31:8]);
        apb(1, `SFTS_CTRL_ADDR, 32'h130);
        apb(0, `SFTS_CTRL_ADDR, 0);
        chk("mode_bad", `SFTS_MODE_EXT, rd[5:4]);
        f0 = n_fire;
        apb(1, `SFTS_CTRL_ADDR, 32'h100);
        frames(3);
        chk("int_back", 2, n_fire - f0);
        $display("test manual done");
        test_done;
    end
endmodule
